// ---- common/serial_eeprom_three_wire_defs.vh ----
// Purpose: Constants of the three-wire serial memory command sequencer
// Assumes: Core clock of 100 MHz
// Notes: Offsets are byte addresses of the plain register port
`ifndef SERIAL_EEPROM_THREE_WIRE_DEFS_VH
`define SERIAL_EEPROM_THREE_WIRE_DEFS_VH

// Register offsets
`define EE_CMD_OFS 4'h0
`define EE_BYTE_OFS 4'h4
`define EE_STRAP_OFS 4'h8

// Command register fields
`define EE_CMD_GO_BIT 31
`define EE_CMD_CODE_HI 30
`define EE_CMD_CODE_LO 28
`define EE_CMD_TMO_BIT 27
`define EE_CMD_ADDR_HI 10
`define EE_CMD_ADDR_LO 0

// Command codes in the command register
`define EE_CODE_READ 3'h0
`define EE_CODE_WRITE 3'h1
`define EE_CODE_ERASE 3'h2
`define EE_CODE_CLEAR_ALL 3'h3
`define EE_CODE_FILL_ALL 3'h4
`define EE_CODE_LOCK 3'h5
`define EE_CODE_UNLOCK 3'h6

// Serial opcodes and subcodes
`define EE_OP_READ 2'h2
`define EE_OP_WRITE 2'h1
`define EE_OP_ERASE 2'h3
`define EE_OP_MISC 2'h0
`define EE_SUB_CLEAR_ALL 2'h2
`define EE_SUB_LOCK 2'h0
`define EE_SUB_UNLOCK 2'h3
`define EE_SUB_FILL_ALL 2'h1

// Size strap codes and address widths
`define EE_SIZE_7 2'h0
`define EE_SIZE_9 2'h1
`define EE_SIZE_11 2'h2
`define EE_TYPE_THREE_WIRE 1'b1

// Timing
`define EE_CLK_NS 10
`define EE_HALF_NS 1000
`define EE_HALF_CYC 7'd100
`define EE_TIMEOUT_MS 30
`define EE_TIMEOUT_CYC 22'd3000000
`define EE_READY_SETTLE 22'd2

// Reset values
`define EE_BYTE_RST 8'h00
`define EE_ADDR_RST 11'h000

`endif

// ---- dv/serial_eeprom_three_wire_cmd_chk.sv ----
// Purpose: Port assertions for the serial memory sequencer
// Assumes: Straps static after reset
// Notes: Bound from the testbench top
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_three_wire_cmd_chk (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic eeprom_type_strap_in,
   input wire logic [1:0] eeprom_size_strap_in,
   input wire logic mem_select_out,
   input wire logic mem_sclk_out,
   input wire logic mem_data_out,
   input wire logic cmd_in_progress_out,
   input wire logic cmd_timeout_flag_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   logic go;
   logic clr;
   assign go = wr_in && addr_in == 4'h0 && wdata_in[31] && eeprom_type_strap_in
      && eeprom_size_strap_in != 2'h3;
   assign clr = wr_in && addr_in == 4'h0 && wdata_in[27];
   busy_start_a: assert property (go && !cmd_in_progress_out |=> cmd_in_progress_out)
      else $error("busy not raised");
   sel_busy_a: assert property (mem_select_out |-> cmd_in_progress_out)
      else $error("select without busy");
   sclk_sel_a: assert property (mem_sclk_out |-> mem_select_out)
      else $error("clock outside frame");
   sclk_high_a: assert property ($rose(mem_sclk_out) |-> ##100 $fell(mem_sclk_out))
      else $error("clock high time");
   data_hold_a: assert property (mem_sclk_out |-> $stable(mem_data_out))
      else $error("data moved while clock high");
   sel_gap_a: assert property ($fell(mem_select_out) |-> !mem_select_out [*8])
      else $error("select gap short");
   rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data outside slot");
   tmo_sticky_a: assert property (cmd_timeout_flag_out && !clr |=> cmd_timeout_flag_out)
      else $error("timeout flag lost");
   tmo_busy_a: assert property ($rose(cmd_timeout_flag_out) |-> cmd_in_progress_out)
      else $error("timeout while idle");
   cover property ($fell(cmd_in_progress_out));
   cover property ($rose(cmd_timeout_flag_out));
   cover property (rd_in ##1 rdata_out != 32'h0);
endmodule
`default_nettype wire

// ---- dv/serial_eeprom_three_wire_cmd_test.sv ----
// Purpose: Self-checking bench of the serial memory sequencer
// Assumes: Short timeout of 200 cycles
// Notes: Frames judged at the memory model
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_three_wire_cmd_test;
   logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, stuck = 1'b0, ty = 1'b1;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, d;
   logic [1:0] sz = 2'h0;
   wire logic [31:0] rdat, lbits;
   wire logic sel, sclk, dout, din, busy, tmo;
   wire logic [4:0] lcnt;
   int num_errors = 0, checks_done = 0, aw = 7;
   always #5 clk = ~clk;
   serial_eeprom_three_wire_cmd #(.TIMEOUT_CYC(22'd200)) DUT (.core_clk_in(clk),
      .resetn_in(resetn), .addr_in(adr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdat), .eeprom_type_strap_in(ty), .eeprom_size_strap_in(sz),
      .mem_data_in(din), .mem_select_out(sel), .mem_sclk_out(sclk), .mem_data_out(dout),
      .cmd_in_progress_out(busy), .cmd_timeout_flag_out(tmo));
   serial_mem_model mem (.clk_in(clk), .sclk_in(sclk), .sel_in(sel), .di_in(dout),
      .stuck_in(stuck), .aw_in(aw[3:0]), .do_out(din), .last_cnt_out(lcnt),
      .last_bits_out(lbits));
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      adr <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdat;
   endtask
   task automatic do_reset(input logic t, input logic [1:0] s);
      @(posedge clk);
      resetn <= 1'b0;
      ty <= t;
      sz <= s;
      aw = 7 + 2 * s;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   function automatic logic [31:0] frame(input logic [2:0] c, input logic [10:0] l,
      input logic [7:0] dt);
      logic [31:0] v;
      logic [1:0] op;
      op = c == 3'h0 ? 2'h2 : c == 3'h1 ? 2'h1 : c == 3'h2 ? 2'h3 : 2'h0;
      v = {29'h0, 1'b1, op};
      v = (v << aw) | (op != 2'h0 ? 32'(l) & ((32'h1 << aw) - 1) :
         32'({c == 3'h3 || c == 3'h6, c == 3'h4 || c == 3'h6}) << (aw - 2));
      if (c == 3'h0 || c == 3'h1 || c == 3'h4) v = (v << 8) | dt;
      return v;
   endfunction
   task automatic run(input logic [2:0] c, input logic [10:0] l, input logic [7:0] dt);
      int n;
      int k;
      n = 0;
      k = c == 3'h0 ? 8 : 0;
      wreg(4'h0, {1'b1, c, 17'h0, l});
      #1 chk("busy", 32'h1, busy);
      while (busy === 1'b1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk("done", 32'h1, n < 20000);
      chk("clocks", 3 + aw + (c < 2 || c == 4 ? 8 : 0), lcnt);
      chk("frame", frame(c, l, dt) >> k, lbits >> k);
   endtask
   task automatic t_modify;
      run(3'h1, 11'h03, 8'h00);
      run(3'h0, 11'h03, 8'h00);
      rreg(4'h4, d);
      chk("locked byte", 32'h03, d);
      run(3'h6, 11'h0, 8'h0);
      wreg(4'h4, 32'ha5);
      run(3'h1, 11'h55, 8'ha5);
      run(3'h0, 11'h55, 8'h0);
      rreg(4'h4, d);
      chk("read byte", 32'ha5, d);
      wreg(4'h4, 32'h3c);
      run(3'h4, 11'h0, 8'h3c);
      run(3'h0, 11'h10, 8'h0);
      rreg(4'h4, d);
      chk("fill byte", 32'h3c, d);
      run(3'h2, 11'h10, 8'h0);
      run(3'h0, 11'h10, 8'h0);
      rreg(4'h4, d);
      chk("erased byte", 32'hff, d);
      run(3'h3, 11'h0, 8'h0);
      run(3'h5, 11'h0, 8'h0);
      wreg(4'h4, 32'h11);
      run(3'h1, 11'h20, 8'h11);
      run(3'h0, 11'h20, 8'h0);
      rreg(4'h4, d);
      chk("cleared byte", 32'hff, d);
      $display("t_modify done");
   endtask
   task automatic t_timeout;
      @(posedge clk);
      stuck <= 1'b1;
      wreg(4'h4, 32'h77);
      run(3'h1, 11'h01, 8'h77);
      rreg(4'h0, d);
      chk("timeout bit", 32'h1, d[27]);
      @(posedge clk);
      stuck <= 1'b0;
      wreg(4'h0, 32'h0800_0000);
      rreg(4'h0, d);
      chk("timeout clear", 32'h0, d[27]);
      $display("t_timeout done");
   endtask
   task automatic t_sizes;
      for (int s = 1; s < 4; s++) begin
         do_reset(1'b1, s[1:0]);
         rreg(4'h8, d);
         chk("strap", {29'h0, s[1:0], 1'b1}, d);
         if (s < 3) run(3'h0, 11'h5a5, 8'h0);
         if (s < 3) run(3'h2, 11'h7ff, 8'h0);
      end
      wreg(4'h0, 32'h8000_0000);
      #1 chk("reserved size", 32'h0, {busy, sel});
      do_reset(1'b0, 2'h0);
      rreg(4'h8, d);
      chk("type strap", 32'h0, d);
      wreg(4'h0, 32'h8000_0000);
      #1 chk("type refused", 32'h0, {busy, sel});
      rreg(4'hc, d);
      chk("unmapped", 32'h0, d);
      $display("t_sizes done");
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_modify;
      t_timeout;
      t_sizes;
      conclude;
   end
   initial begin
      #900000;
      num_errors++;
      conclude;
   end
endmodule
bind serial_eeprom_three_wire_cmd serial_eeprom_three_wire_cmd_chk chk_i (
   .core_clk_in(core_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .eeprom_type_strap_in(eeprom_type_strap_in), .eeprom_size_strap_in(eeprom_size_strap_in),
   .mem_select_out(mem_select_out), .mem_sclk_out(mem_sclk_out),
   .mem_data_out(mem_data_out), .cmd_in_progress_out(cmd_in_progress_out),
   .cmd_timeout_flag_out(cmd_timeout_flag_out));
`default_nettype wire

// ---- dv/serial_mem_model.sv ----
// Purpose: Behavioural three-wire serial memory
// Assumes: Clock pin sampled on the core clock
// Notes: Data line toggles while deselected
`timescale 1ns/100ps
`default_nettype none
module serial_mem_model #(
   parameter int BUSY = 150
) (
   input wire logic clk_in,
   input wire logic sclk_in,
   input wire logic sel_in,
   input wire logic di_in,
   input wire logic stuck_in,
   input wire logic [3:0] aw_in,
   output logic do_out,
   output logic [4:0] last_cnt_out,
   output logic [31:0] last_bits_out
);
   logic [7:0] mem [0:2047];
   logic open_q = 1'b0;
   logic sclk_q = 1'b0, sel_q = 1'b0, tog_q = 1'b0, rdph_q = 1'b0;
   logic [4:0] cnt_q = 5'h0;
   logic [31:0] sh_q = 32'h0, m;
   logic [7:0] rd_q = 8'h0;
   logic [10:0] a;
   int busy_q = 0;
   assign m = (32'h1 << aw_in) - 32'h1;
   assign do_out = !sel_in ? tog_q : rdph_q ? rd_q[7] : busy_q == 0 && !stuck_in;
   initial for (int i = 0; i < 2048; i++) mem[i] = i[7:0];
   always @(posedge clk_in) begin
      sclk_q <= sclk_in;
      sel_q <= sel_in;
      tog_q <= ~tog_q;
      if (busy_q > 0) busy_q <= busy_q - 1;
      if (sel_in && sclk_in && !sclk_q) begin
         sh_q <= {sh_q[30:0], di_in};
         cnt_q <= cnt_q + 5'h1;
         rd_q <= {rd_q[6:0], 1'b0};
         if (cnt_q == 3 + aw_in && sh_q[aw_in +: 2] == 2'h2) begin
            rd_q <= mem[sh_q & m];
            rdph_q <= 1'b1;
         end
      end
      if (sel_q && !sel_in && cnt_q != 5'h0) begin
         last_cnt_out <= cnt_q;
         last_bits_out <= sh_q;
         cnt_q <= 5'h0;
         sh_q <= 32'h0;
         rdph_q <= 1'b0;
         a = 11'(sh_q & m);
         if (cnt_q == 3 + aw_in && sh_q[aw_in +: 2] == 2'h3 && open_q) begin
            mem[a] = 8'hff;
            busy_q <= BUSY;
         end else if (cnt_q == 3 + aw_in && sh_q[aw_in +: 2] == 2'h0) begin
            case (sh_q[aw_in - 2 +: 2])
               2'h0: open_q <= 1'b0;
               2'h3: open_q <= 1'b1;
               2'h2: if (open_q) begin
                  for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
                  busy_q <= BUSY;
               end
               default: ;
            endcase
         end else if (cnt_q == 11 + aw_in && open_q && sh_q[aw_in + 8 +: 2] != 2'h2) begin
            a = 11'((sh_q >> 8) & m);
            if (sh_q[aw_in + 8 +: 2] == 2'h1) mem[a] = sh_q[7:0];
            else for (int i = 0; i < 2048; i++) mem[i] = sh_q[7:0];
            busy_q <= BUSY;
         end
      end
   end
endmodule
`default_nettype wire

// ---- logic/serial_eeprom_three_wire_cmd.v ----
// Purpose: Sequencer issuing instructions to a three-wire serial memory
// Assumes: Straps are static after reset; memory holds its data line high when ready
// Notes: Serial clock is made here by a divider of the core clock
//
// How it works
// RULE_01: Commands run only when the type strap selects the three-wire protocol.
// RULE_02: Size strap 00, 01, 10 give 7, 9, 11 address bits; 11 reserved.
// RULE_03: Every address bit of the selected width is shifted out as programmed.
// RULE_04: Frame starts with bit 1, then opcode 10 read, 01 write, 11 erase, else 00.
// RULE_05: Opcode 00 puts a subcode in the two top address bits, rest zero.
// RULE_06: Seven-bit mode uses 10 clocks without data and 18 clocks with data.
// RULE_07: Nine-bit mode uses 12 clocks without data and 20 clocks with data.
// RULE_08: Address goes MSB first, then data bit 7 to 0 out or in.
// RULE_09: Eleven-bit mode uses 14 clocks without data and 22 clocks with data.
// RULE_10: After erase or write kinds, wait for ready; 30 ms without it sets timeout.
// RULE_11: The memory clears one location on erase when unlocked.
// RULE_12: The memory clears its whole array on clear-all when unlocked.
// RULE_13: After the lock instruction the memory ignores erase and write.
// RULE_14: After unlock the memory accepts erase and write until lock or power loss.
// RULE_15: The memory powers up locked.
// RULE_16: A read places the fetched byte in the byte register.
// RULE_17: A write sends the byte register to the commanded location.
// RULE_18: A fill sends the byte register to every location.
// RULE_19: Busy stays set from frame start until frame, wait or timeout ends.
// RULE_20: Chip select covers each frame and drops between frames and before ready.
`include "serial_eeprom_three_wire_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_three_wire_cmd #(
   parameter [21:0] TIMEOUT_CYC = `EE_TIMEOUT_CYC
) (
   input wire core_clk_in,
   input wire resetn_in,
   input wire [3:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rdata_out,
   input wire eeprom_type_strap_in,
   input wire [1:0] eeprom_size_strap_in,
   input wire mem_data_in,
   output reg mem_select_out,
   output reg mem_sclk_out,
   output reg mem_data_out,
   output reg cmd_in_progress_out,
   output reg cmd_timeout_flag_out
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_SHIFT = 3'h1;
   localparam [2:0] ST_GAP = 3'h2;
   localparam [2:0] ST_WAIT = 3'h3;
   localparam [2:0] ST_END = 3'h4;

   // Address width for a size code
   function [4:0] addr_bits;
      input [1:0] sz;
      begin
         case (sz)
            `EE_SIZE_7: addr_bits = 5'd7;
            `EE_SIZE_9: addr_bits = 5'd9;
            default: addr_bits = 5'd11;
         endcase
      end
   endfunction

   // True for commands carrying a data byte
   function has_data;
      input [2:0] code;
      begin
         has_data = (code == `EE_CODE_READ) || (code == `EE_CODE_WRITE) ||
                    (code == `EE_CODE_FILL_ALL);
      end
   endfunction

   // Frame bits, right aligned
   function [21:0] build_frame;
      input [2:0] code;
      input [1:0] sz;
      input [10:0] adr;
      input [7:0] dat;
      reg [1:0] op;
      reg [1:0] sub;
      reg [4:0] ab;
      reg [21:0] mask;
      reg [21:0] w;
      begin
         ab = addr_bits(sz);
         sub = `EE_SUB_LOCK;
         case (code)
            `EE_CODE_READ: op = `EE_OP_READ;
            `EE_CODE_WRITE: op = `EE_OP_WRITE;
            `EE_CODE_ERASE: op = `EE_OP_ERASE;
            default: op = `EE_OP_MISC;
         endcase
         case (code)
            `EE_CODE_CLEAR_ALL: sub = `EE_SUB_CLEAR_ALL;
            `EE_CODE_FILL_ALL: sub = `EE_SUB_FILL_ALL;
            `EE_CODE_UNLOCK: sub = `EE_SUB_UNLOCK;
            default: sub = `EE_SUB_LOCK;
         endcase
         mask = (22'h000001 << ab) - 22'h000001;
         w = {19'h00000, 1'b1, op} << ab; // RULE_04
         if (op == `EE_OP_MISC) begin
            w = w | ({20'h00000, sub} << (ab - 5'd2)); // RULE_05
         end else begin
            w = w | ({11'h000, adr} & mask); // RULE_03
         end
         if (has_data(code)) begin
            w = (w << 8) | {14'h0000, dat}; // RULE_08
         end
         build_frame = w;
      end
   endfunction

   // Strap synchronisers and capture
   reg type_s1_q;
   reg type_s2_q;
   reg [1:0] size_s1_q;
   reg [1:0] size_s2_q;
   reg [1:0] strap_cnt_q;
   reg type_q;
   reg [1:0] size_q;
   // Memory data line synchroniser
   reg din_s1_q;
   reg din_s2_q;
   // Software state
   reg [2:0] code_q;
   reg [10:0] loc_q;
   reg [7:0] byte_q;
   // Sequencer
   reg [2:0] state_q;
   reg [21:0] frame_q;
   reg [4:0] cnt_q;
   reg [7:0] rx_q;
   reg [6:0] div_q;
   reg [21:0] tmo_q;

   wire tick = (div_q == 7'd0);
   wire cmd_wr = wr_in && (addr_in == `EE_CMD_OFS);
   wire byte_wr = wr_in && (addr_in == `EE_BYTE_OFS);
   wire go = cmd_wr && wdata_in[`EE_CMD_GO_BIT] && !cmd_in_progress_out;
   wire can_run = (type_q == `EE_TYPE_THREE_WIRE) && (size_q != 2'h3);
   wire [2:0] new_code = wdata_in[`EE_CMD_CODE_HI:`EE_CMD_CODE_LO];
   wire [10:0] new_loc = wdata_in[`EE_CMD_ADDR_HI:`EE_CMD_ADDR_LO];
   wire [4:0] new_len = 5'd3 + addr_bits(size_q) + (has_data(new_code) ? 5'd8 : 5'd0);
   wire [21:0] new_frame = build_frame(new_code, size_q, new_loc, byte_q); // RULE_17 RULE_18
   wire needs_wait = (code_q == `EE_CODE_WRITE) || (code_q == `EE_CODE_ERASE) ||
                     (code_q == `EE_CODE_CLEAR_ALL) || (code_q == `EE_CODE_FILL_ALL);
   wire in_data = has_data(code_q) && (cnt_q <= 5'd8);
   wire tmo_set = (state_q == ST_WAIT) && !din_s2_q && (tmo_q == 22'h000000);
   wire tmo_clr = cmd_wr && wdata_in[`EE_CMD_TMO_BIT];
   // Ready counts only once the synchroniser holds samples taken after select rose
   wire ready_ok = din_s2_q && (tmo_q <= (TIMEOUT_CYC - `EE_READY_SETTLE));

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         type_s1_q <= 1'b0;
         type_s2_q <= 1'b0;
         size_s1_q <= 2'h0;
         size_s2_q <= 2'h0;
         strap_cnt_q <= 2'h0;
         type_q <= 1'b0;
         size_q <= 2'h3;
         din_s1_q <= 1'b0;
         din_s2_q <= 1'b0;
      end else begin
         type_s1_q <= eeprom_type_strap_in;
         type_s2_q <= type_s1_q;
         size_s1_q <= eeprom_size_strap_in;
         size_s2_q <= size_s1_q;
         din_s1_q <= mem_data_in;
         din_s2_q <= din_s1_q;
         if (strap_cnt_q != 2'h3) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
         // Straps taken once, third edge after reset
         if (strap_cnt_q == 2'h2) begin
            type_q <= type_s2_q; // RULE_01
            size_q <= size_s2_q; // RULE_02
         end
      end
   end

   // Register reads, data one cycle after the strobe
   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= 32'h00000000;
      end else if (rd_in) begin
         case (addr_in)
            `EE_CMD_OFS: rdata_out <= {cmd_in_progress_out, code_q, cmd_timeout_flag_out,
                                       16'h0000, loc_q};
            `EE_BYTE_OFS: rdata_out <= {24'h000000, byte_q};
            `EE_STRAP_OFS: rdata_out <= {29'h00000000, size_q, type_q};
            default: rdata_out <= 32'h00000000;
         endcase
      end else begin
         rdata_out <= 32'h00000000;
      end
   end

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         code_q <= `EE_CODE_READ;
         loc_q <= `EE_ADDR_RST;
         byte_q <= `EE_BYTE_RST;
         state_q <= ST_IDLE;
         frame_q <= 22'h000000;
         cnt_q <= 5'd0;
         rx_q <= 8'h00;
         div_q <= 7'd0;
         tmo_q <= 22'h000000;
         mem_select_out <= 1'b0;
         mem_sclk_out <= 1'b0;
         mem_data_out <= 1'b0;
         cmd_in_progress_out <= 1'b0;
         cmd_timeout_flag_out <= 1'b0;
      end else begin
         // Serial clock half-period divider
         div_q <= tick ? (`EE_HALF_CYC - 7'd1) : (div_q - 7'd1);
         // Sticky timeout, set wins over clear
         if (tmo_set) begin
            cmd_timeout_flag_out <= 1'b1; // RULE_10
         end else if (tmo_clr) begin
            cmd_timeout_flag_out <= 1'b0;
         end
         // Byte register closed to port writes while busy
         if (byte_wr && !cmd_in_progress_out) begin
            byte_q <= wdata_in[7:0];
         end
         // Frame states
         case (state_q)
            ST_IDLE: begin
               if (go && can_run) begin
                  code_q <= new_code;
                  loc_q <= new_loc;
                  frame_q <= new_frame << (5'd22 - new_len); // RULE_06 RULE_07 RULE_09
                  cnt_q <= new_len;
                  cmd_in_progress_out <= 1'b1; // RULE_19
                  state_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (tick) begin
                  if (!mem_select_out) begin
                     mem_select_out <= 1'b1; // RULE_20
                     mem_data_out <= frame_q[21];
                  end else if (!mem_sclk_out) begin
                     mem_sclk_out <= 1'b1;
                  end else begin
                     mem_sclk_out <= 1'b0;
                     if (in_data && (code_q == `EE_CODE_READ)) begin
                        rx_q <= {rx_q[6:0], din_s2_q}; // RULE_08
                     end
                     frame_q <= {frame_q[20:0], 1'b0};
                     mem_data_out <= frame_q[20]; // RULE_08
                     cnt_q <= cnt_q - 5'd1;
                     if (cnt_q == 5'd1) begin
                        mem_data_out <= 1'b0;
                        mem_select_out <= 1'b0; // RULE_20
                        state_q <= ST_GAP;
                     end
                  end
               end
            end
            ST_GAP: begin
               if (tick) begin
                  if (code_q == `EE_CODE_READ) begin
                     byte_q <= rx_q; // RULE_16
                  end
                  if (needs_wait) begin
                     mem_select_out <= 1'b1; // RULE_20
                     tmo_q <= TIMEOUT_CYC;
                     state_q <= ST_WAIT;
                  end else begin
                     state_q <= ST_END;
                  end
               end
            end
            ST_WAIT: begin
               // Poll ready until it shows or the count runs out
               tmo_q <= tmo_q - 22'h000001;
               if (ready_ok || (tmo_q == 22'h000000)) begin
                  mem_select_out <= 1'b0; // RULE_10
                  state_q <= ST_END;
               end
            end
            ST_END: begin
               if (tick) begin
                  cmd_in_progress_out <= 1'b0; // RULE_19
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire
